// ### hdl/ecdf_unit.v
// One timer/counter: edge total, edge divider and frequency modes
//
// The address map and register access over APB were chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ecdf_consts.vh"
module ecdf_unit #(
    parameter CW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire [1:0] mode,
    input wire inv,
    input wire init_lvl,
    input wire [3:0] clk_sel,
    input wire cnt_edge,
    input wire val_wr,
    input wire [CW-1:0] val_wdata,
    input wire cnt_rd,
    output reg [CW-1:0] cnt_rdata,
    output wire running,
    output wire out_lvl
);
    localparam integer BASE_DIV_I = (`ECDF_CLK_MHZ * `ECDF_PERIOD_UNIT_NS) / (`ECDF_BASE_MHZ * 1000 * 2);
    localparam [15:0] BASE_DIV = BASE_DIV_I[15:0];
    reg [CW-1:0] div_q;
    reg [CW-1:0] pend_q;
    reg pend_v_q;
    reg run_q;
    reg out_q;
    reg [CW-1:0] ecnt_q;
    reg [15:0] pre_q;
    reg [15:0] tick_q;
    reg [CW:0] hcnt_q;
    reg wrote_q;
    wire [CW:0] half_len;
    wire tick;
    wire [15:0] tick_mask;
    assign tick_mask = (16'h0001 << clk_sel) - 16'h0001;
    assign tick = (pre_q == BASE_DIV - 16'h0001) && ((tick_q & tick_mask) == tick_mask);
    // Period (value+k) units, k=1 for select 0; half of that per level
    assign half_len = {1'b0, div_q} + ((clk_sel == 4'h0) ? {{CW{1'b0}}, 1'b1} : {(CW+1){1'b0}});
    assign running = run_q;
    assign out_lvl = out_q;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            cnt_rdata <= {CW{1'b0}};
            div_q <= {CW{1'b0}};
            pend_q <= {CW{1'b0}};
            pend_v_q <= 1'b0;
            run_q <= 1'b0;
            out_q <= 1'b0;
            ecnt_q <= {CW{1'b0}};
            pre_q <= 16'h0000;
            tick_q <= 16'h0000;
            hcnt_q <= {(CW+1){1'b0}};
            wrote_q <= 1'b0;
        end
        else
        begin
            if (pre_q == BASE_DIV - 16'h0001)
            begin
                pre_q <= 16'h0000;
                tick_q <= tick_q + 16'h0001;
            end
            else
            begin
                pre_q <= pre_q + 16'h0001;
            end
            // Edge total: live count read and cleared at one edge, edge in read cycle kept
            if (mode == `ECDF_MODE_TOTAL)
            begin
                if (cnt_rd)
                begin
                    cnt_rdata <= cnt_edge ? {{(CW-1){1'b0}}, 1'b1} : {CW{1'b0}};
                end
                else if (cnt_edge && cnt_rdata != {CW{1'b1}})
                begin
                    cnt_rdata <= cnt_rdata + {{(CW-1){1'b0}}, 1'b1};
                end
            end
            else if (mode == `ECDF_MODE_OFF)
            begin
                out_q <= init_lvl;
                run_q <= 1'b0;
            end
            if (mode == `ECDF_MODE_DIVIDE)
            begin
                if (val_wr && val_wdata == {CW{1'b0}})
                begin
                    run_q <= 1'b0;
                    out_q <= 1'b0;
                    pend_v_q <= 1'b0;
                end
                else if (val_wr && !run_q)
                begin
                    div_q <= val_wdata;
                    pend_v_q <= 1'b0;
                    run_q <= 1'b1;
                    ecnt_q <= {CW{1'b0}};
                    if (!wrote_q)
                    begin
                        out_q <= 1'b1;
                    end
                    wrote_q <= 1'b1;
                end
                else if (run_q)
                begin
                    if (val_wr)
                    begin
                        pend_q <= val_wdata;
                        pend_v_q <= 1'b1;
                    end
                    if (cnt_edge)
                    begin
                        if (ecnt_q + {{(CW-1){1'b0}}, 1'b1} >= div_q)
                        begin
                            out_q <= ~out_q;
                            ecnt_q <= {CW{1'b0}};
                            if (pend_v_q && !val_wr)
                            begin
                                div_q <= pend_q;
                                pend_v_q <= 1'b0;
                            end
                        end
                        else
                        begin
                            ecnt_q <= ecnt_q + {{(CW-1){1'b0}}, 1'b1};
                        end
                    end
                end
            end
            else if (mode == `ECDF_MODE_FREQ)
            begin
                if (val_wr && val_wdata == {CW{1'b0}})
                begin
                    run_q <= 1'b0;
                    out_q <= inv;
                    pend_v_q <= 1'b0;
                end
                else if (val_wr && !run_q)
                begin
                    div_q <= val_wdata;
                    pend_v_q <= 1'b0;
                    run_q <= 1'b1;
                    hcnt_q <= {(CW+1){1'b0}};
                    out_q <= ~inv;
                end
                else if (run_q)
                begin
                    if (val_wr)
                    begin
                        pend_q <= val_wdata;
                        pend_v_q <= 1'b1;
                    end
                    if (tick)
                    begin
                        if (hcnt_q + {{CW{1'b0}}, 1'b1} >= half_len)
                        begin
                            hcnt_q <= {(CW+1){1'b0}};
                            out_q <= ~out_q;
                            // End of cycle is the falling back to start level
                            if (out_q == inv && pend_v_q && !val_wr)
                            begin
                                div_q <= pend_q;
                                pend_v_q <= 1'b0;
                            end
                        end
                        else
                        begin
                            hcnt_q <= hcnt_q + {{CW{1'b0}}, 1'b1};
                        end
                    end
                end
                else
                begin
                    out_q <= inv;
                end
            end
        end
    end
endmodule
`default_nettype wire

// ### hdl/ecdf_consts.vh
// Register offsets, field positions and timing constants for the timer block
`ifndef ECDF_CONSTS_VH
`define ECDF_CONSTS_VH
`define ECDF_OFF_CTRL0 12'h000
`define ECDF_OFF_VAL0 12'h004
`define ECDF_OFF_CNT0 12'h008
`define ECDF_OFF_STAT0 12'h00c
`define ECDF_OFF_CTRL1 12'h010
`define ECDF_OFF_VAL1 12'h014
`define ECDF_OFF_CNT1 12'h018
`define ECDF_OFF_STAT1 12'h01c
`define ECDF_CTRL_MODE_LSB 0
`define ECDF_CTRL_INV_BIT 2
`define ECDF_CTRL_INIT_BIT 3
`define ECDF_CTRL_SEL_LSB 4
`define ECDF_CTRL_CLK_LSB 8
`define ECDF_CTRL_RST 32'h00000000
`define ECDF_MODE_OFF 2'h0
`define ECDF_MODE_TOTAL 2'h1
`define ECDF_MODE_DIVIDE 2'h2
`define ECDF_MODE_FREQ 2'h3
`define ECDF_PERIOD_UNIT_NS 4000
`define ECDF_BASE_MHZ 10
`define ECDF_CLK_MHZ 50
`endif

// ### hdl/ecdf_edge.v
// Input synchroniser and one-polarity edge detector
`timescale 1ns/1ns
`default_nettype none
module ecdf_edge (
    input wire pclk,
    input wire presetn,
    input wire din,
    input wire rise_sel,
    output wire edge_pulse
);
    reg s1_q;
    reg s2_q;
    reg s3_q;
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s1_q <= 1'b0;
            s2_q <= 1'b0;
            s3_q <= 1'b0;
        end
        else
        begin
            s1_q <= din;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end
    // One polarity only
    assign edge_pulse = rise_sel ? (s2_q & ~s3_q) : (~s2_q & s3_q);
endmodule
`default_nettype wire

// ### hdl/ecdf_top.v
// APB top: two timer/counters, input routing and output lines
// Summary of operation
// - Edge total counts one chosen edge polarity, never both.
// - Edge total read returns 16-bit unsigned count since previous read.
// - Counter clears right after each edge total read, to one if an edge lands in the read cycle.
// - Falling edge counted by default, rising when invert is set.
// - Input lines four to seven; line four may use either counter.
// - Two counters: one multiplexed input, one fixed input.
// - Divider toggles output every n active edges, n from 1 upward.
// - Divisor zero forces output off and halts divider at once.
// - New divisor waits for next toggle unless divider was stopped.
// - Divider counts falling edges by default, rising when inverted.
// - After reset the first divisor write drives output high and starts.
// - Running divider: nonzero write updates divisor, output unchanged.
// - Divider output goes high on its first start, later keeps its level; initial level is loaded only in off mode.
// - Divider line zero uses mux counter, line one dedicated on four.
// - Period is (value+k) units times two to the clock select.
// - Wide select runs zero to fifteen over a fixed base clock.
// - Frequency mode gives continuous square wave of equal halves.
// - New frequency value applies at cycle end, or at once if stopped.
// - Frequency value zero disables the output immediately.
// - Disabled frequency output rests at zero, or one when inverted.
// - Frequency output on line zero for mux, line one for dedicated.
// - Clock select zero is fastest, fifteen slowest, default zero.
`timescale 1ns/1ns
`default_nettype none
`include "ecdf_consts.vh"
module ecdf_top #(
    parameter CW = 16
) (
    input wire pclk,
    input wire presetn,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [11:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output wire pready,
    output wire pslverr,
    input wire [3:0] io_in_hi,
    output wire io_out0,
    output wire io_out1
);
    reg [31:0] ctrl0_q;
    reg [31:0] ctrl1_q;
    reg [CW-1:0] val0_q;
    reg [CW-1:0] val1_q;
    wire acc;
    wire wr;
    wire rd;
    wire [1:0] m0;
    wire [1:0] m1;
    wire [1:0] sel0;
    wire in0;
    wire e0;
    wire e1;
    wire [CW-1:0] cnt0;
    wire [CW-1:0] cnt1;
    wire run0;
    wire run1;
    wire hit;
    wire rd_cnt0;
    wire rd_cnt1;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    assign pready = 1'b1;
    assign hit = (paddr[11:5] == 7'h00) && (paddr[1:0] == 2'h0);
    assign pslverr = acc & ~hit;
    assign m0 = ctrl0_q[`ECDF_CTRL_MODE_LSB+1:`ECDF_CTRL_MODE_LSB];
    assign m1 = ctrl1_q[`ECDF_CTRL_MODE_LSB+1:`ECDF_CTRL_MODE_LSB];
    assign sel0 = ctrl0_q[`ECDF_CTRL_SEL_LSB+1:`ECDF_CTRL_SEL_LSB];
    // Mux counter picks line 4..7, dedicated fixed on line 4
    assign in0 = io_in_hi[sel0];
    assign rd_cnt0 = rd && paddr == `ECDF_OFF_CNT0;
    assign rd_cnt1 = rd && paddr == `ECDF_OFF_CNT1;
    ecdf_edge u_edge0 (
        .pclk(pclk),
        .presetn(presetn),
        .din(in0),
        .rise_sel(ctrl0_q[`ECDF_CTRL_INV_BIT]),
        .edge_pulse(e0)
    );
    ecdf_edge u_edge1 (
        .pclk(pclk),
        .presetn(presetn),
        .din(io_in_hi[0]),
        .rise_sel(ctrl1_q[`ECDF_CTRL_INV_BIT]),
        .edge_pulse(e1)
    );
    ecdf_unit #(.CW(CW)) u_mux (
        .pclk(pclk),
        .presetn(presetn),
        .mode(m0),
        .inv(ctrl0_q[`ECDF_CTRL_INV_BIT]),
        .init_lvl(ctrl0_q[`ECDF_CTRL_INIT_BIT]),
        .clk_sel(ctrl0_q[`ECDF_CTRL_CLK_LSB+3:`ECDF_CTRL_CLK_LSB]),
        .cnt_edge(e0),
        .val_wr(wr && paddr == `ECDF_OFF_VAL0),
        .val_wdata(pwdata[CW-1:0]),
        .cnt_rd(rd_cnt0),
        .cnt_rdata(cnt0),
        .running(run0),
        .out_lvl(io_out0)
    );
    ecdf_unit #(.CW(CW)) u_ded (
        .pclk(pclk),
        .presetn(presetn),
        .mode(m1),
        .inv(ctrl1_q[`ECDF_CTRL_INV_BIT]),
        .init_lvl(ctrl1_q[`ECDF_CTRL_INIT_BIT]),
        .clk_sel(ctrl1_q[`ECDF_CTRL_CLK_LSB+3:`ECDF_CTRL_CLK_LSB]),
        .cnt_edge(e1),
        .val_wr(wr && paddr == `ECDF_OFF_VAL1),
        .val_wdata(pwdata[CW-1:0]),
        .cnt_rd(rd_cnt1),
        .cnt_rdata(cnt1),
        .running(run1),
        .out_lvl(io_out1)
    );
    always @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl0_q <= `ECDF_CTRL_RST;
            ctrl1_q <= `ECDF_CTRL_RST;
            val0_q <= {CW{1'b0}};
            val1_q <= {CW{1'b0}};
        end
        else if (wr)
        begin
            if (paddr == `ECDF_OFF_CTRL0)
            begin
                ctrl0_q <= {20'h00000, pwdata[11:8], 2'h0, pwdata[5:0]};
            end
            if (paddr == `ECDF_OFF_CTRL1)
            begin
                ctrl1_q <= {20'h00000, pwdata[11:8], 4'h0, pwdata[3:0]};
            end
            if (paddr == `ECDF_OFF_VAL0)
            begin
                val0_q <= pwdata[CW-1:0];
            end
            if (paddr == `ECDF_OFF_VAL1)
            begin
                val1_q <= pwdata[CW-1:0];
            end
        end
    end
    // Count registers show the live count; the read edge clears it
    always @*
    begin
        prdata = 32'h00000000;
        if (rd)
        begin
            case (paddr)
                `ECDF_OFF_CTRL0: prdata = ctrl0_q;
                `ECDF_OFF_CTRL1: prdata = ctrl1_q;
                `ECDF_OFF_VAL0: prdata = {{(32-CW){1'b0}}, val0_q};
                `ECDF_OFF_VAL1: prdata = {{(32-CW){1'b0}}, val1_q};
                `ECDF_OFF_CNT0: prdata = {{(32-CW){1'b0}}, cnt0};
                `ECDF_OFF_CNT1: prdata = {{(32-CW){1'b0}}, cnt1};
                `ECDF_OFF_STAT0: prdata = {30'h00000000, io_out0, run0};
                `ECDF_OFF_STAT1: prdata = {30'h00000000, io_out1, run1};
                default: prdata = 32'h00000000;
            endcase
        end
    end
endmodule
`default_nettype wire

// ### verif/ecdf_src.sv
// Pulse source model driving input lines four to seven
`timescale 1ns/1ns
`default_nettype none
module ecdf_src (
    input wire logic pclk,
    output logic [3:0] lines
);
    initial lines = 4'hf;
    // Each level held at least two clocks, so at most a quarter of the clock rate
    task automatic pulses(input int ln, input int n, input int hold);
        int h;
        begin
            h = (hold < 2) ? 2 : hold;
            repeat (n)
            begin
                @(posedge pclk) lines[ln] <= 1'b0;
                repeat (h) @(posedge pclk);
                lines[ln] <= 1'b1;
                repeat (h - 1) @(posedge pclk);
            end
        end
    endtask
    task automatic level(input int ln, input logic v);
        @(posedge pclk) lines[ln] <= v;
    endtask
endmodule
`default_nettype wire

// ### verif/ecdf_chk.sv
// Port checker for the timer block
`timescale 1ns/1ns
`default_nettype none
module ecdf_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [3:0] io_in_hi,
    input wire logic io_out0,
    input wire logic io_out1
);
    logic [11:0] c0_q, c1_q;
    logic [15:0] v0_q;
    logic [3:0] in_q, q0_q, q1_q;
    logic [1:0] n0_q;
    logic [31:0] run_q;
    logic d0_q, o0_q;
    wire wr = psel && penable && pready && pwrite;
    wire wv0 = wr && paddr == 12'h004;
    wire [31:0] half0 = ({16'h0000, v0_q} + {31'h0, c0_q[11:8] == 4'h0}) * 32'h0000000a << c0_q[11:8];
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            c0_q <= 12'h000;
            c1_q <= 12'h000;
            v0_q <= 16'h0000;
            in_q <= 4'h0;
            q0_q <= 4'h0;
            q1_q <= 4'h0;
            n0_q <= 2'h0;
            run_q <= 32'h0;
            d0_q <= 1'b0;
            o0_q <= 1'b0;
        end
        else
        begin
            if (wr && paddr == 12'h000) c0_q <= pwdata[11:0];
            if (wr && paddr == 12'h010) c1_q <= pwdata[11:0];
            if (wv0) v0_q <= pwdata[15:0];
            if (wv0 && c0_q[1:0] == 2'h2 && pwdata[15:0] != 16'h0000) d0_q <= 1'b1;
            in_q <= io_in_hi;
            q0_q <= (wr || io_in_hi != in_q) ? 4'h0 : q0_q + {3'h0, q0_q != 4'hf};
            q1_q <= (wr || io_in_hi[0] != in_q[0]) ? 4'h0 : q1_q + {3'h0, q1_q != 4'hf};
            o0_q <= io_out0;
            run_q <= (io_out0 != o0_q) ? 32'h1 : run_q + 32'h1;
            n0_q <= wr ? 2'h0 : n0_q + {1'b0, io_out0 != o0_q && n0_q != 2'h3};
        end
    end
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_cnt_width: assert property (psel && penable && !pwrite && (paddr == 12'h008 || paddr == 12'h018)
        |-> prdata[31:16] == 16'h0000) else $error("count read wider than 16 bits");
    a_div_zero: assert property (wv0 && c0_q[1:0] == 2'h2 && pwdata[15:0] == 16'h0000
        |=> !io_out0 [*3]) else $error("divider zero write left output on");
    a_freq_zero: assert property (wv0 && c0_q[1:0] == 2'h3 && pwdata[15:0] == 16'h0000
        |=> (io_out0 == c0_q[2]) [*2]) else $error("frequency zero write not at rest level");
    a_div_first: assert property (wv0 && c0_q[1:0] == 2'h2 && !d0_q && pwdata[15:0] != 16'h0000
        |=> io_out0) else $error("first divisor write did not raise output");
    a_div_keep: assert property (wv0 && c0_q[1:0] == 2'h2 && d0_q && v0_q != 16'h0000
        && pwdata[15:0] != 16'h0000 && q0_q > 4'h4 |=> $stable(io_out0)) else $error("divisor update moved output");
    a_div_edge0: assert property (c0_q[1:0] == 2'h2 && q0_q > 4'h5 |-> $stable(io_out0))
        else $error("divider output moved without an input edge");
    a_div_edge1: assert property (c1_q[1:0] == 2'h2 && q1_q > 4'h5 |-> $stable(io_out1))
        else $error("dedicated divider moved without line four edge");
    a_freq_half: assert property (c0_q[1:0] == 2'h3 && n0_q == 2'h3 && io_out0 != o0_q
        |-> run_q == half0) else $error("frequency half period wrong");
    c_freq: cover property (c0_q[1:0] == 2'h3 && n0_q == 2'h3 && io_out0 != o0_q);
    c_div: cover property (c0_q[1:0] == 2'h2 && $changed(io_out0) && !wr);
    c_cnt: cover property (psel && penable && paddr == 12'h008 && prdata != 32'h0);
endmodule
bind ecdf_top ecdf_chk u_ecdf_chk (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .io_in_hi(io_in_hi), .io_out0(io_out0), .io_out1(io_out1));
`default_nettype wire

// ### verif/ecdf_top_tb.sv
// Self-checking bench for the timer block
`timescale 1ns/1ns
`default_nettype none
`define CHK(n, e, g) begin checks++; if ((g) !== (e)) begin mismatches++; $display("Error %s exp %0h got %0h", n, e, g); end end
module ecdf_top_tb;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, rd;
    logic er;
    wire [31:0] prdata;
    wire pready, pslverr, io_out0, io_out1;
    wire [3:0] lines;
    int mismatches = 0, checks = 0, cyc = 0;
    ecdf_top u_ecdf_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .io_in_hi(lines), .io_out0(io_out0), .io_out1(io_out1));
    ecdf_src u_ecdf_src (.pclk(pclk), .lines(lines));
    initial forever #10 pclk = ~pclk;
    task automatic finish_test();
        if (mismatches == 0 && checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            mismatches++;
            finish_test();
        end
    end
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge pclk);
    endtask
    function automatic logic oo(input int u);
        return u ? io_out1 : io_out0;
    endfunction
    task automatic half(input int u, output int h);
        logic v;
        begin
            v = oo(u);
            h = 0;
            while (oo(u) === v && h < 9000)
            begin
                @(posedge pclk);
                h++;
            end
        end
    endtask
    task automatic t_reset();
        apb(1'b0, 12'h000, 0);
        `CHK("ctrl0", 32'h0, rd)
        apb(1'b0, 12'h01c, 0);
        `CHK("stat1", 32'h0, rd)
        `CHK("out0", 1'b0, io_out0)
        apb(1'b0, 12'h020, 0);
        `CHK("unmapped", 1'b1, er)
    endtask
    task automatic t_total(input int u, input int sel, input int inv, input int n);
        logic [11:0] b;
        int ln;
        begin
            b = u ? 12'h010 : 12'h000;
            ln = u ? 0 : sel;
            wr(b, 1 + inv * 4 + sel * 16);
            tick(8);
            apb(1'b0, b + 12'h008, 0);
            u_ecdf_src.pulses(ln, n, 2);
            u_ecdf_src.pulses(ln ^ 1, 2, 3);
            u_ecdf_src.level(ln, 1'b0);
            tick(8);
            apb(1'b0, b + 12'h008, 0);
            `CHK("count", n + (inv == 0), rd)
            apb(1'b0, b + 12'h008, 0);
            `CHK("cleared", 32'h0, rd)
            u_ecdf_src.level(ln, 1'b1);
            tick(8);
        end
    endtask
    task automatic t_div(input int u, input int sel, input int inv);
        logic [11:0] b;
        int ln;
        logic v;
        begin
            b = u ? 12'h010 : 12'h000;
            ln = u ? 0 : sel;
            wr(b, 2 + inv * 4 + sel * 16);
            wr(b + 12'h004, 3);
            tick(2);
            `CHK("div start", 1'b1, oo(u))
            u_ecdf_src.pulses(ln, 2, 2);
            u_ecdf_src.level(ln, 1'b0);
            tick(8);
            `CHK("div edge", inv != 0, oo(u))
            u_ecdf_src.level(ln, 1'b1);
            tick(8);
            `CHK("div n", 1'b0, oo(u))
            wr(b + 12'h004, 2);
            tick(2);
            `CHK("div keep", 1'b0, oo(u))
            u_ecdf_src.pulses(ln, 2, 2);
            tick(8);
            `CHK("div old n", 1'b0, oo(u))
            u_ecdf_src.pulses(ln, 1, 2);
            tick(8);
            `CHK("div toggle", 1'b1, oo(u))
            wr(b + 12'h004, 0);
            tick(1);
            `CHK("div zero", 1'b0, oo(u))
            apb(1'b0, b + 12'h00c, 0);
            `CHK("div halted", 1'b0, rd[0])
            u_ecdf_src.pulses(ln, 3, 2);
            tick(8);
            `CHK("div stays", 1'b0, oo(u))
            wr(b + 12'h004, 2);
            tick(2);
            v = oo(u);
            u_ecdf_src.pulses(ln, 2, 2);
            tick(8);
            `CHK("div restart", ~v, oo(u))
            wr(b + 12'h004, 0);
        end
    endtask
    task automatic t_freq(input int u, input int sel, input int v, input int inv);
        logic [11:0] b;
        int h;
        begin
            b = u ? 12'h010 : 12'h000;
            wr(b, 3 + inv * 4 + sel * 256);
            tick(2);
            `CHK("freq idle", inv != 0, oo(u))
            wr(b + 12'h004, v);
            `CHK("freq start", inv == 0, oo(u))
            half(u, h);
            half(u, h);
            `CHK("freq half", (v + (sel == 0)) * 10 << sel, h)
            half(u, h);
            `CHK("freq other half", (v + (sel == 0)) * 10 << sel, h)
            wr(b + 12'h004, v + 1);
            half(u, h);
            half(u, h);
            `CHK("freq cycle end", (v + 1 + (sel == 0)) * 10 << sel, h)
            half(u, h);
            `CHK("freq new", (v + 1 + (sel == 0)) * 10 << sel, h)
            wr(b + 12'h004, 0);
            tick(1);
            `CHK("freq zero", inv != 0, oo(u))
            tick(50);
            `CHK("freq rest", inv != 0, oo(u))
        end
    endtask
    task automatic t_init();
        wr(12'h010, 8);
        tick(2);
        `CHK("init one", 1'b1, io_out1)
        wr(12'h010, 0);
        tick(2);
        `CHK("init zero", 1'b0, io_out1)
    endtask
    initial
    begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        t_reset();
        for (int s = 0; s < 4; s++) t_total(0, s, s % 2, 3 + s);
        t_total(1, 0, 0, 4);
        t_total(1, 0, 1, 2);
        t_div(0, 2, 0);
        t_div(1, 0, 1);
        t_freq(0, 0, 2, 0);
        t_freq(0, 1, 1, 1);
        t_freq(1, 2, 1, 0);
        t_init();
        finish_test();
    end
endmodule
`default_nettype wire
